// >>> logic/dpa_data_path.sv
// Processor data path: decoder, ALU, status register, scratch pad
`timescale 1ns/1ps
`default_nettype none
module dpa_data_path #(
  parameter dpa_pkg::dpa_word_t STAT_ADDR = dpa_pkg::STAT_BUS_ADDR,
  parameter dpa_pkg::dpa_word_t SWITCH_ADDR = dpa_pkg::SWITCH_BUS_ADDR,
  parameter dpa_pkg::dpa_word_t RED_ZONE_MARGIN = dpa_pkg::RED_MARGIN
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire dpa_pkg::dpa_sel_t micro_alu_select,
  input wire logic micro_alu_mode,
  input wire logic micro_carry_in,
  input wire dpa_pkg::dpa_alt_e data_alteration_code,
  input wire dpa_pkg::dpa_ssel_e status_source_select,
  input wire logic cc_n_in,
  input wire logic cc_z_in,
  input wire logic cc_v_in,
  input wire logic cc_c_in,
  input wire logic alu_overflow_in,
  input wire dpa_pkg::dpa_word_t alu_b_operand,
  input wire dpa_pkg::dpa_dmux_e dest_mux_select,
  input wire dpa_pkg::dpa_cout_e carry_mux_select,
  input wire logic d_load,
  input wire logic ba_load,
  input wire logic ba_from_alu,
  input wire logic ir_load,
  input wire logic sp_write,
  input wire dpa_pkg::dpa_sp_addr_t sp_write_addr,
  input wire dpa_pkg::dpa_sp_addr_t sp_read_addr,
  input wire logic sp_to_read_return,
  input wire logic stat_to_read_return,
  input wire logic sysbus_slave_read,
  input wire dpa_pkg::dpa_word_t sysbus_data_in,
  input wire dpa_pkg::dpa_word_t read_return_in,
  input wire dpa_pkg::dpa_word_t stack_limit,
  output dpa_pkg::dpa_word_t dest_bus,
  output dpa_pkg::dpa_word_t read_return,
  output dpa_pkg::dpa_word_t alu_result,
  output logic word_carry_out,
  output logic byte_carry_out,
  output dpa_pkg::dpa_word_t data_reg,
  output logic data_carry,
  output dpa_pkg::dpa_word_t bus_address,
  output dpa_pkg::dpa_word_t instruction_reg,
  output dpa_pkg::dpa_stat_t processor_status_word,
  output dpa_pkg::dpa_word_t sysbus_data_out,
  output logic sysbus_data_oe,
  output logic d_word_zero,
  output logic d_byte_zero,
  output logic status_reg_addr_hit,
  output logic switch_reg_addr_hit,
  output logic stack_limit_violation,
  output logic stack_limit_fatal
);
  import dpa_pkg::*;

  // ----------------------------------------------------------------
  // Decoder on the data and bus-address registers
  // ----------------------------------------------------------------
  // zero detect
  assign d_word_zero = (data_reg == '0);
  assign d_byte_zero = (data_reg[BYTE_W-1:0] == '0);
  wire dpa_word_t decoded_addr = bus_address;
  assign status_reg_addr_hit = (decoded_addr == STAT_ADDR);
  assign switch_reg_addr_hit = (decoded_addr == SWITCH_ADDR);
  assign stack_limit_violation = (decoded_addr < stack_limit);
  // red zone below margin; saturate so a small limit never wraps
  wire dpa_word_t red_limit = (stack_limit > RED_ZONE_MARGIN) ? (stack_limit - RED_ZONE_MARGIN) : '0;
  assign stack_limit_fatal = stack_limit_violation && (decoded_addr < red_limit);

  // ----------------------------------------------------------------
  // ALU control
  // ----------------------------------------------------------------
  wire logic ir_sub = instruction_reg[IR_SUB_BIT];
  wire logic [1:0] ir_lop = instruction_reg[IR_LOP_HI:IR_LOP_LO];
  wire dpa_sel_t lop_sel = (ir_lop == 2'h0) ? FN_PASS_B :
                           (ir_lop == 2'h1) ? FN_AND_NOT_B :
                           (ir_lop == 2'h2) ? FN_OR : FN_XOR;
  dpa_sel_t alu_sel;
  logic alu_logic_mode;
  logic carry_in_logic;

  // microword direct or altered by instruction
  always_comb begin
    alu_sel = micro_alu_select;
    alu_logic_mode = micro_alu_mode;
    carry_in_logic = micro_carry_in;
    unique case (data_alteration_code)
      ALT_DIRECT: begin
      end
      ALT_ADD_SUB: begin
        alu_sel = ir_sub ? FN_MINUS : FN_PLUS;
        alu_logic_mode = 1'b0;
        carry_in_logic = ir_sub;
      end
      ALT_CARRY_IR: begin
        carry_in_logic = micro_carry_in ^ ir_sub;
      end
      ALT_LOGIC_IR: begin
        alu_sel = lop_sel;
        alu_logic_mode = 1'b1;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // ALU
  // ----------------------------------------------------------------
  // Two intermediate terms shared by both modes, one per select pair
  wire dpa_word_t alu_a_operand;
  wire dpa_word_t alu_b = alu_b_operand;
  wire dpa_word_t term_x = alu_a_operand | (alu_b & {WORD_W{alu_sel[0]}}) | (~alu_b & {WORD_W{alu_sel[1]}});
  wire dpa_word_t term_y = (alu_a_operand & ~alu_b & {WORD_W{alu_sel[2]}}) |
                           (alu_a_operand & alu_b & {WORD_W{alu_sel[3]}});
  wire logic [WORD_W:0] arith_sum = {1'b0, term_x} + {1'b0, term_y} + {{WORD_W{1'b0}}, carry_in_logic};
  wire logic [BYTE_W:0] byte_sum = {1'b0, term_x[BYTE_W-1:0]} + {1'b0, term_y[BYTE_W-1:0]} +
                                   {{BYTE_W{1'b0}}, carry_in_logic};
  // logic result has no carry term
  wire dpa_word_t logic_result = ~(term_x ^ term_y);
  assign alu_result = alu_logic_mode ? logic_result : arith_sum[WORD_W-1:0];
  assign word_carry_out = ~alu_logic_mode & arith_sum[WORD_W];
  assign byte_carry_out = ~alu_logic_mode & byte_sum[BYTE_W];

  // ----------------------------------------------------------------
  // Destination mux and read-return bus
  // ----------------------------------------------------------------
  wire dpa_word_t sp_read_data;
  assign alu_a_operand = sp_read_data;
  wire dpa_word_t stat_word = {{(WORD_W-STAT_W){1'b0}}, processor_status_word};
  // status to internal return when not on system bus
  wire logic stat_on_return = stat_to_read_return && !(sysbus_slave_read && status_reg_addr_hit);
  assign read_return = read_return_in |
                       (sp_to_read_return ? sp_read_data : '0) |
                       (stat_on_return ? stat_word : '0);
  always_comb begin
    unique case (dest_mux_select)
      DMUX_READ_RETURN: dest_bus = read_return;
      DMUX_SYSBUS: dest_bus = sysbus_data_in;
      DMUX_DREG: dest_bus = data_reg;
      DMUX_DREG_SHR: dest_bus = {data_carry, data_reg[WORD_W-1:1]};
    endcase
  end

  wire logic carry_mux = (carry_mux_select == COUT_WORD) ? word_carry_out :
                         (carry_mux_select == COUT_BYTE) ? byte_carry_out :
                         (carry_mux_select == COUT_ALU15) ? alu_result[WORD_W-1] :
                         processor_status_word[STAT_C];

  // ----------------------------------------------------------------
  // Data, address and instruction registers
  // ----------------------------------------------------------------
  // ALU result capture; bus address from ALU result or read return
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      data_reg <= '0;
      data_carry <= 1'b0;
      bus_address <= '0;
    end else begin
      if (d_load) begin
        data_reg <= alu_result;
        data_carry <= carry_mux;
      end
      if (ba_load) begin
        bus_address <= ba_from_alu ? alu_result : read_return;
      end
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      instruction_reg <= '0;
    end else if (ir_load) begin
      instruction_reg <= dest_bus;
    end
  end

  // ----------------------------------------------------------------
  // Processor status register
  // ----------------------------------------------------------------
  dpa_stat_t next_stat;
  // source code picks the condition inputs
  wire logic [3:0] cc_alu = {alu_result[WORD_W-1], alu_result == '0, alu_overflow_in, carry_mux};
  wire logic [3:0] cc_ext = {cc_n_in, cc_z_in, cc_v_in, cc_c_in};
  always_comb begin
    next_stat = processor_status_word;
    unique case (status_source_select)
      SSEL_HOLD: begin
      end
      SSEL_LOAD: next_stat = dest_bus[STAT_W-1:0];
      SSEL_CC_ALU: next_stat[STAT_N:STAT_C] = cc_alu;
      SSEL_CC_EXT: next_stat[STAT_N:STAT_C] = cc_ext;
    endcase
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      processor_status_word <= STAT_RESET;
    end else begin
      processor_status_word <= next_stat;
    end
  end

  // status onto system bus when addressed there
  assign sysbus_data_oe = sysbus_slave_read && status_reg_addr_hit;
  assign sysbus_data_out = sysbus_data_oe ? stat_word : '0;

  // ----------------------------------------------------------------
  // Scratch pad
  // ----------------------------------------------------------------
  // sixteen-word file written from destination bus
  dpa_scratch_pad #(
    .DEPTH(SP_DEPTH),
    .WIDTH(WORD_W)
  ) u_scratch_pad (
    .clock(clock),
    .wr_en(sp_write),
    .wr_addr(sp_write_addr),
    .wr_data(dest_bus),
    .rd_addr(sp_read_addr),
    .rd_data(sp_read_data)
  );

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  wire dpa_word_t arith_no_carry = term_x + term_y;

  property p_zero_detect;
    @(posedge clock) disable iff (!arst_n)
    d_load && (alu_result == '0) |=> d_word_zero && d_byte_zero;
  endproperty
  a_zero_detect: assert property (p_zero_detect) else $error("zero flag missed");

  property p_addr_hit;
    @(posedge clock) disable iff (!arst_n)
    ba_load && ba_from_alu && (alu_result == STAT_ADDR) |=> status_reg_addr_hit && !switch_reg_addr_hit;
  endproperty
  a_addr_hit: assert property (p_addr_hit) else $error("status address hit missed");

  property p_stack_limit;
    @(posedge clock) disable iff (!arst_n)
    stack_limit_violation == (bus_address < stack_limit);
  endproperty
  a_stack_limit: assert property (p_stack_limit) else $error("stack limit flag wrong");

  property p_fatal_zone;
    @(posedge clock) disable iff (!arst_n)
    stack_limit_fatal |-> stack_limit_violation && (bus_address < stack_limit - RED_ZONE_MARGIN);
  endproperty
  a_fatal_zone: assert property (p_fatal_zone) else $error("fatal zone without violation");

  property p_cin_plus_one;
    @(posedge clock) disable iff (!arst_n)
    !alu_logic_mode && carry_in_logic |-> alu_result == arith_no_carry + 16'h0001;
  endproperty
  a_cin_plus_one: assert property (p_cin_plus_one) else $error("carry-in not plus one");

  property p_logic_no_carry;
    @(posedge clock) disable iff (!arst_n)
    alu_logic_mode |-> alu_result == ~(term_x ^ term_y) && !word_carry_out && !byte_carry_out;
  endproperty
  a_logic_no_carry: assert property (p_logic_no_carry) else $error("logic mode used carry");

  property p_d_capture;
    @(posedge clock) disable iff (!arst_n)
    d_load |=> data_reg == $past(alu_result) && data_carry == $past(carry_mux);
  endproperty
  a_d_capture: assert property (p_d_capture) else $error("data register missed result");

  property p_ir_hold;
    @(posedge clock) disable iff (!arst_n)
    !ir_load |=> $stable(instruction_reg);
  endproperty
  a_ir_hold: assert property (p_ir_hold) else $error("instruction register changed unasked");

  property p_stat_load;
    @(posedge clock) disable iff (!arst_n)
    status_source_select == SSEL_LOAD |=> processor_status_word == $past(dest_bus[STAT_W-1:0]);
  endproperty
  a_stat_load: assert property (p_stat_load) else $error("status full load failed");

  property p_stat_route;
    @(posedge clock) disable iff (!arst_n)
    sysbus_data_oe |-> !stat_on_return && sysbus_data_out == stat_word;
  endproperty
  a_stat_route: assert property (p_stat_route) else $error("status on both buses");

  c_fatal: cover property (@(posedge clock) disable iff (!arst_n) stack_limit_fatal);
  c_stat_sysbus: cover property (@(posedge clock) disable iff (!arst_n) sysbus_data_oe);
  c_sub_ir: cover property (@(posedge clock) disable iff (!arst_n) data_alteration_code == ALT_ADD_SUB && ir_sub);
  c_shift: cover property (@(posedge clock) disable iff (!arst_n) dest_mux_select == DMUX_DREG_SHR && data_carry);
endmodule
`default_nettype wire

// >>> logic/dpa_pkg.sv
// Shared constants and types for the processor data path
package dpa_pkg;

  // ----------------------------------------------------------------
  // Widths and types
  // ----------------------------------------------------------------
  localparam int WORD_W = 16;
  localparam int BYTE_W = 8;
  localparam int SEL_W = 4;
  localparam int SP_DEPTH = 16;
  localparam int SP_AW = 4;
  typedef logic [WORD_W-1:0] dpa_word_t;
  typedef logic [SEL_W-1:0] dpa_sel_t;
  typedef logic [SP_AW-1:0] dpa_sp_addr_t;

  // ----------------------------------------------------------------
  // Status register layout
  // ----------------------------------------------------------------
  localparam int STAT_W = 8;
  localparam int STAT_PRI_HI = 7;
  localparam int STAT_PRI_LO = 5;
  localparam int STAT_T = 4;
  localparam int STAT_N = 3;
  localparam int STAT_Z = 2;
  localparam int STAT_V = 1;
  localparam int STAT_C = 0;
  localparam logic [STAT_W-1:0] STAT_RESET = 8'h00;
  typedef logic [STAT_W-1:0] dpa_stat_t;

  // ----------------------------------------------------------------
  // Select codes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    DMUX_READ_RETURN = 2'h0,
    DMUX_SYSBUS = 2'h1,
    DMUX_DREG = 2'h2,
    DMUX_DREG_SHR = 2'h3
  } dpa_dmux_e;

  typedef enum logic [1:0] {
    COUT_WORD = 2'h0,
    COUT_BYTE = 2'h1,
    COUT_ALU15 = 2'h2,
    COUT_PSC = 2'h3
  } dpa_cout_e;

  typedef enum logic [1:0] {
    SSEL_HOLD = 2'h0,
    SSEL_LOAD = 2'h1,
    SSEL_CC_ALU = 2'h2,
    SSEL_CC_EXT = 2'h3
  } dpa_ssel_e;

  typedef enum logic [1:0] {
    ALT_DIRECT = 2'h0,
    ALT_ADD_SUB = 2'h1,
    ALT_CARRY_IR = 2'h2,
    ALT_LOGIC_IR = 2'h3
  } dpa_alt_e;

  // Function-select codes used by the alteration logic
  localparam logic [SEL_W-1:0] FN_PLUS = 4'h9;
  localparam logic [SEL_W-1:0] FN_MINUS = 4'h6;
  localparam logic [SEL_W-1:0] FN_AND_NOT_B = 4'h2;
  localparam logic [SEL_W-1:0] FN_OR = 4'he;
  localparam logic [SEL_W-1:0] FN_PASS_B = 4'ha;
  localparam logic [SEL_W-1:0] FN_XOR = 4'h6;

  // Instruction register fields used by the alteration logic
  localparam int IR_SUB_BIT = 15;
  localparam int IR_LOP_HI = 13;
  localparam int IR_LOP_LO = 12;

  // Internal bus addresses (plain defaults, set per system)
  localparam logic [WORD_W-1:0] STAT_BUS_ADDR = 16'hfffe;
  localparam logic [WORD_W-1:0] SWITCH_BUS_ADDR = 16'hff78;
  localparam logic [WORD_W-1:0] RED_MARGIN = 16'h0020;

endpackage

// >>> logic/dpa_scratch_pad.sv
// Scratch-pad register file with registered read data
`timescale 1ns/1ps
`default_nettype none
module dpa_scratch_pad #(
  parameter int DEPTH = dpa_pkg::SP_DEPTH,
  parameter int WIDTH = dpa_pkg::WORD_W
) (
  input wire logic clock,
  input wire logic wr_en,
  input wire logic [$clog2(DEPTH)-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [$clog2(DEPTH)-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);
  import dpa_pkg::*;

  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clock) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule
`default_nettype wire

// >>> tb/dpa_bus_model.sv
// Model of the system bus and of other units on the read-return bus
`timescale 1ns/1ps
`default_nettype none
module dpa_bus_model
  import dpa_pkg::*;
(
  input wire logic clock,
  input wire logic bus_drive,
  input wire dpa_pkg::dpa_word_t bus_word,
  input wire logic rr_drive,
  input wire dpa_pkg::dpa_word_t rr_word,
  output dpa_pkg::dpa_word_t sysbus_data_in,
  output dpa_pkg::dpa_word_t read_return_in
);
  dpa_word_t last_word = 16'h5a5a;
  // Released bus shows the inverse of the last word, so stale data never matches
  assign sysbus_data_in = bus_drive ? bus_word : ~last_word;
  assign read_return_in = rr_drive ? rr_word : 16'h0000;
  always @(posedge clock) begin
    if (bus_drive) begin
      last_word <= bus_word;
    end
  end
endmodule
`default_nettype wire

// >>> tb/testbench.sv
// Self-checking bench for the processor data path
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import dpa_pkg::*;
  logic clock, arst_n, micro_alu_mode, micro_carry_in, cc_n_in, cc_z_in, cc_v_in, cc_c_in;
  logic alu_overflow_in, d_load, ba_load, ba_from_alu, ir_load, sp_write, sp_to_read_return;
  logic stat_to_read_return, sysbus_slave_read, bus_drive, rr_drive, word_carry_out, byte_carry_out;
  logic data_carry, sysbus_data_oe, d_word_zero, d_byte_zero, status_reg_addr_hit, switch_reg_addr_hit;
  logic stack_limit_violation, stack_limit_fatal;
  dpa_sel_t micro_alu_select;
  dpa_alt_e data_alteration_code;
  dpa_ssel_e status_source_select;
  dpa_dmux_e dest_mux_select;
  dpa_cout_e carry_mux_select;
  dpa_sp_addr_t sp_write_addr, sp_read_addr;
  dpa_word_t alu_b_operand, sysbus_data_in, read_return_in, stack_limit, bus_word, rr_word, dest_bus;
  dpa_word_t read_return, alu_result, data_reg, bus_address, instruction_reg, sysbus_data_out;
  dpa_stat_t processor_status_word;
  int errors, cmp_count;
  // Select, mode and carry-in, then the result expected with A 3333 and B 0f0f
  logic [23:0] alu_tbl [16] = '{24'h02cccc, 24'h330000, 24'ha30f0f, 24'hf33333, 24'hc2ffff, 24'h003333,
    24'h013334, 24'h904242, 24'h914243, 24'h612424, 24'h602423, 24'hf03332, 24'hf13333, 24'h30ffff,
    24'h310000, 24'hc06666};
  // Address, then the flags: status hit, switch hit, violation, fatal (limit 1000)
  logic [19:0] addr_tbl [6] = '{{STAT_BUS_ADDR, 4'h8}, {SWITCH_BUS_ADDR, 4'h4}, 20'h0ff02, 20'h0fdf3,
    20'h10000, 20'h0fe02};

  dpa_data_path DUT (.clock(clock), .arst_n(arst_n), .micro_alu_select(micro_alu_select),
    .micro_alu_mode(micro_alu_mode), .micro_carry_in(micro_carry_in), .data_alteration_code(data_alteration_code),
    .status_source_select(status_source_select), .cc_n_in(cc_n_in), .cc_z_in(cc_z_in), .cc_v_in(cc_v_in),
    .cc_c_in(cc_c_in), .alu_overflow_in(alu_overflow_in), .alu_b_operand(alu_b_operand),
    .dest_mux_select(dest_mux_select), .carry_mux_select(carry_mux_select), .d_load(d_load), .ba_load(ba_load),
    .ba_from_alu(ba_from_alu), .ir_load(ir_load), .sp_write(sp_write), .sp_write_addr(sp_write_addr),
    .sp_read_addr(sp_read_addr), .sp_to_read_return(sp_to_read_return), .stat_to_read_return(stat_to_read_return),
    .sysbus_slave_read(sysbus_slave_read), .sysbus_data_in(sysbus_data_in), .read_return_in(read_return_in),
    .stack_limit(stack_limit), .dest_bus(dest_bus), .read_return(read_return), .alu_result(alu_result),
    .word_carry_out(word_carry_out), .byte_carry_out(byte_carry_out), .data_reg(data_reg),
    .data_carry(data_carry), .bus_address(bus_address), .instruction_reg(instruction_reg),
    .processor_status_word(processor_status_word), .sysbus_data_out(sysbus_data_out),
    .sysbus_data_oe(sysbus_data_oe), .d_word_zero(d_word_zero), .d_byte_zero(d_byte_zero),
    .status_reg_addr_hit(status_reg_addr_hit), .switch_reg_addr_hit(switch_reg_addr_hit),
    .stack_limit_violation(stack_limit_violation), .stack_limit_fatal(stack_limit_fatal));
  dpa_bus_model u_bus (.clock(clock), .bus_drive(bus_drive), .bus_word(bus_word), .rr_drive(rr_drive),
    .rr_word(rr_word), .sysbus_data_in(sysbus_data_in), .read_return_in(read_return_in));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  // Wide enough for a 16-bit word plus one flag, so flag-and-word compares keep every bit
  task automatic check(input string what, input logic [16:0] seen, input logic [16:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Strobes are set once per cycle here, so no strobe is written twice in a time step
  task automatic go(input logic [3:0] ld, input dpa_ssel_e ssel);
    {d_load, ba_load, ir_load, sp_write} = ld;
    status_source_select = ssel;
    #9;
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    clock = 0;
    forever #10 clock = ~clock;
  end
  // Whole run is about a hundred cycles
  initial begin
    #200000;
    errors++;
    end_sim();
  end

  initial begin
    errors = 0;
    cmp_count = 0;
    {arst_n, micro_alu_mode, micro_carry_in, cc_n_in, cc_z_in, cc_v_in, cc_c_in, alu_overflow_in} = '0;
    {d_load, ba_load, ba_from_alu, ir_load, sp_write, sp_to_read_return, stat_to_read_return} = '0;
    {sysbus_slave_read, bus_drive, rr_drive, micro_alu_select, sp_write_addr, sp_read_addr} = '0;
    {alu_b_operand, stack_limit, bus_word, rr_word} = '0;
    data_alteration_code = ALT_DIRECT;
    status_source_select = SSEL_HOLD;
    dest_mux_select = DMUX_SYSBUS;
    carry_mux_select = COUT_WORD;
    repeat (10) @(negedge clock);
    arst_n = 1;
    go(4'b0000, SSEL_HOLD);
    check("rst", {data_reg | bus_address | instruction_reg}, 16'h0000);
    check("stat", processor_status_word, {8'h00, STAT_RESET});
    check("zero", {d_word_zero, d_byte_zero}, 16'h3);
    $display("reset test done");
    for (int i = 0; i < 16; i++) begin
      @(negedge clock);
      bus_drive = 1;
      bus_word = dpa_word_t'(16'h1111 * i);
      sp_write_addr = dpa_sp_addr_t'(i);
      go(4'b0001, SSEL_HOLD);
    end
    for (int i = 0; i < 16; i++) begin
      @(negedge clock);
      {bus_drive, rr_drive, sp_to_read_return} = 3'b011;
      rr_word = 16'h0100;
      sp_read_addr = dpa_sp_addr_t'(i);
      go(4'b0000, SSEL_HOLD);
      @(negedge clock);
      go(4'b0000, SSEL_HOLD);
      check("sp", read_return, dpa_word_t'(16'h1111 * i) | 16'h0100);
    end
    $display("register file test done");
    @(negedge clock);
    {rr_drive, sp_to_read_return} = 2'b00;
    sp_read_addr = 4'h3;
    alu_b_operand = 16'h0f0f;
    go(4'b0000, SSEL_HOLD);
    foreach (alu_tbl[i]) begin
      @(negedge clock);
      {micro_alu_select, micro_alu_mode, micro_carry_in} = {alu_tbl[i][23:20], alu_tbl[i][17:16]};
      go(4'b0000, SSEL_HOLD);
      check("alu", alu_result, alu_tbl[i][15:0]);
      if (alu_tbl[i][17]) begin
        check("lcy", word_carry_out, 16'h0);
      end
    end
    $display("function test done");
    @(negedge clock);
    sp_read_addr = 4'hf;
    {micro_alu_select, micro_alu_mode, micro_carry_in} = 6'h24;
    alu_b_operand = 16'h0001;
    go(4'b0000, SSEL_HOLD);
    @(negedge clock);
    sp_read_addr = 4'h1;
    go(4'b1000, SSEL_HOLD);
    check("sum", alu_result, 16'h0000);
    check("cy", {word_carry_out, byte_carry_out}, 16'h3);
    @(negedge clock);
    alu_b_operand = 16'h00ef;
    carry_mux_select = COUT_BYTE;
    go(4'b1000, SSEL_HOLD);
    check("dc", {data_reg, data_carry}, 17'h00001);
    check("zero", {d_word_zero, d_byte_zero}, 16'h3);
    check("sum", alu_result, 16'h1200);
    check("cy", {word_carry_out, byte_carry_out}, 16'h1);
    @(negedge clock);
    dest_mux_select = DMUX_DREG_SHR;
    {micro_alu_select, micro_alu_mode, micro_carry_in} = 6'h3e;
    carry_mux_select = COUT_ALU15;
    go(4'b1000, SSEL_HOLD);
    check("zero", {d_word_zero, d_byte_zero}, 16'h1);
    check("shr", dest_bus, 16'h8900);
    @(negedge clock);
    dest_mux_select = DMUX_DREG;
    go(4'b0000, SSEL_HOLD);
    check("dc", data_carry, 16'h0);
    check("dm", dest_bus, 16'h1111);
    $display("carry test done");
    @(negedge clock);
    dest_mux_select = DMUX_SYSBUS;
    bus_drive = 1;
    bus_word = 16'h12a5;
    {cc_n_in, cc_z_in, cc_v_in, cc_c_in} = 4'hb;
    go(4'b0000, SSEL_LOAD);
    @(negedge clock);
    go(4'b0000, SSEL_CC_EXT);
    check("stat", processor_status_word, 16'h00a5);
    @(negedge clock);
    {micro_alu_select, micro_alu_mode, micro_carry_in} = 6'h0e;
    alu_overflow_in = 1;
    carry_mux_select = COUT_PSC;
    go(4'b1000, SSEL_HOLD);
    check("stat", processor_status_word, 16'h00ab);
    @(negedge clock);
    go(4'b0000, SSEL_CC_ALU);
    check("stat", processor_status_word, 16'h00ab);
    check("dc", data_carry, 16'h1);
    @(negedge clock);
    go(4'b0000, SSEL_HOLD);
    check("stat", processor_status_word, 16'h00a7);
    $display("status test done");
    foreach (addr_tbl[i]) begin
      @(negedge clock);
      {micro_alu_select, micro_alu_mode, micro_carry_in} = 6'h2a;
      alu_b_operand = addr_tbl[i][19:4];
      bus_word = STAT_BUS_ADDR;
      stack_limit = 16'h1000;
      ba_from_alu = 1;
      go(4'b0100, SSEL_HOLD);
      @(negedge clock);
      go(4'b0000, SSEL_HOLD);
      check("ba", bus_address, addr_tbl[i][19:4]);
      check("decode", {status_reg_addr_hit, switch_reg_addr_hit, stack_limit_violation, stack_limit_fatal},
        addr_tbl[i][3:0]);
    end
    $display("decode test done");
    @(negedge clock);
    alu_b_operand = STAT_BUS_ADDR;
    go(4'b0100, SSEL_HOLD);
    @(negedge clock);
    {sysbus_slave_read, stat_to_read_return} = 2'b11;
    go(4'b0000, SSEL_HOLD);
    check("sbd", {sysbus_data_oe, sysbus_data_out}, 17'h100a7);
    check("rr", read_return, 16'h0000);
    @(negedge clock);
    sysbus_slave_read = 0;
    go(4'b0000, SSEL_HOLD);
    check("oe", sysbus_data_oe, 16'h0);
    check("rr", read_return, 16'h00a7);
    $display("bus read test done");
    @(negedge clock);
    {stat_to_read_return, ba_from_alu, rr_drive} = 3'b001;
    rr_word = 16'h4321;
    bus_word = 16'h8000;
    go(4'b0100, SSEL_HOLD);
    @(negedge clock);
    go(4'b0000, SSEL_HOLD);
    check("ba", bus_address, 16'h4321);
    check("ir", instruction_reg, 16'h0000);
    @(negedge clock);
    sp_read_addr = 4'h3;
    alu_b_operand = 16'h0f0f;
    data_alteration_code = ALT_ADD_SUB;
    go(4'b0010, SSEL_HOLD);
    @(negedge clock);
    go(4'b0000, SSEL_HOLD);
    check("ir", instruction_reg, 16'h8000);
    check("sub", alu_result, 16'h2424);
    // Instruction bit 15 set flips the microword carry-in: plain add becomes add plus one
    @(negedge clock);
    {micro_alu_select, micro_alu_mode, micro_carry_in} = 6'h24;
    data_alteration_code = ALT_CARRY_IR;
    go(4'b0000, SSEL_HOLD);
    check("cir", alu_result, 16'h4243);
    // Instruction bits 13:12 are zero here, which selects pass-B in logic mode
    @(negedge clock);
    data_alteration_code = ALT_LOGIC_IR;
    go(4'b0000, SSEL_HOLD);
    check("lir", alu_result, 16'h0f0f);
    $display("instruction test done");
    end_sim();
  end
endmodule
`default_nettype wire
